// file: tb/scm_checker.sv
// assertions for the safe code sequence monitor
`timescale 1ns/10ps
module scm_checker #(
	parameter int SHUTDOWN_CYCLES = 50,
	parameter int RESTART_CYCLES = 100
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// received telegram
	input wire logic telegramValid,
	input wire logic [4:0] telegramAddr,
	input wire logic [3:0] telegramCode,
	// configuration
	input wire logic learnRequest,
	input wire logic [30:0] slaveEnable,
	input wire logic [30:0] tripMapCirc0,
	input wire logic [30:0] tripMapCirc1,
	input wire logic [1:0] twoChannel,
	// fault reset
	input wire logic faultResetValid,
	input wire logic [4:0] faultResetAddr,
	// monitor outputs
	input wire logic [1:0] enableCh1,
	input wire logic [1:0] enableCh2,
	input wire logic [30:0] slaveFault,
	input wire logic [3:0] diagWord
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [31:0] quietCnt;
	logic [31:0] gapCnt;
	// saturating, and wide enough for the full-length timer defaults
	always_ff @(posedge clk) begin
		if (reset || diagWord[3] || |(slaveFault & tripMapCirc0)) quietCnt <= 32'h0;
		else if (quietCnt != 32'hffffffff) quietCnt <= quietCnt + 32'h1;
	end
	always_ff @(posedge clk) begin
		if (reset || diagWord[3] || (telegramValid && telegramAddr == 5'h01)) gapCnt <= 32'h0;
		else if (gapCnt != 32'hffffffff) gapCnt <= gapCnt + 32'h1;
	end
	a_ch2_follow: assert property (enableCh2 == (enableCh1 & $past(twoChannel)))
		else $error("second channel wrong");
	a_learn_open: assert property (diagWord[3] && $past(diagWord[3]) |-> enableCh1 == 2'h0)
		else $error("closed in learn");
	a_map_circ0: assert property (|(slaveFault & tripMapCirc0) |-> !enableCh1[0])
		else $error("circuit 0 closed on fault");
	a_map_circ1: assert property (|(slaveFault & tripMapCirc1) |-> !enableCh1[1])
		else $error("circuit 1 closed on fault");
	a_diag_state: assert property (diagWord[2:1] == enableCh1)
		else $error("diag circuit bits");
	a_restart_wait: assert property ($rose(enableCh1[0]) |-> quietCnt >= RESTART_CYCLES)
		else $error("restart too early");
	a_silence_trip: assert property (gapCnt > SHUTDOWN_CYCLES + 4 && slaveEnable[0] |-> slaveFault[0])
		else $error("missing telegram not tripped");
	a_reset_local: assert property (slaveFault[1] && faultResetValid && faultResetAddr == 5'h01
		|=> ##1 slaveFault[1]) else $error("reset cleared other slave");
	a_diag_fault: assert property (diagWord[0] == |slaveFault)
		else $error("diag fault bit wrong");
	a_idle_quiet: assert property ((slaveFault & ~$past(slaveEnable, 2)) == 31'h0)
		else $error("disabled slot faulted");
	c_mismatch: cover property ($rose(slaveFault[1]));
	c_restart: cover property ($rose(enableCh1[0]));
	c_learn_done: cover property ($fell(diagWord[3]));
endmodule // scm_checker

bind scm_monitor scm_checker #(
	.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES),
	.RESTART_CYCLES(RESTART_CYCLES)
) i_scm_checker (
	.clk(clk),
	.reset(reset),
	.telegramValid(telegramValid),
	.telegramAddr(telegramAddr),
	.telegramCode(telegramCode),
	.learnRequest(learnRequest),
	.slaveEnable(slaveEnable),
	.tripMapCirc0(tripMapCirc0),
	.tripMapCirc1(tripMapCirc1),
	.twoChannel(twoChannel),
	.faultResetValid(faultResetValid),
	.faultResetAddr(faultResetAddr),
	.enableCh1(enableCh1),
	.enableCh2(enableCh2),
	.slaveFault(slaveFault),
	.diagWord(diagWord)
);

// file: tb/scm_slave_model.sv
// safe slaves on the bus, each stepping through its own code sequence
`timescale 1ns/10ps
module scm_slave_model (
	// clock and poll request from the master
	input wire logic clk,
	input wire logic poll,
	input wire logic [4:0] pollAddr,
	// fault injection on the returned word
	input wire logic [3:0] corrupt,
	// slave reply
	output logic telegramValid,
	output logic [4:0] telegramAddr,
	output logic [3:0] telegramCode
);
	logic [2:0] idx [32];
	logic [3:0] noise = 4'h0;
	initial for (int i = 0; i < 32; i++) idx[i] = 3'h0;
	// a slave moves to its next word only when polled
	always @(posedge clk) begin
		noise <= noise + 4'h7;
		if (poll) idx[pollAddr] <= idx[pollAddr] + 3'h1;
	end
	assign telegramValid = poll;
	assign telegramAddr = pollAddr;
	// idle cycles carry a moving pattern so a stale word is never seen
	assign telegramCode = poll ? (pollAddr[3:0] + {idx[pollAddr], 1'b1}) ^ corrupt : noise;
endmodule // scm_slave_model

// file: tb/tb.sv
// self-checking bench for the safe code sequence monitor
`timescale 1ns/10ps
module tb;
	localparam int SHUT = 50;
	localparam int REST = 100;
	logic clk = 1'b0, reset = 1'b1, poll = 1'b0, learnRequest = 1'b0, faultResetValid = 1'b0;
	logic [4:0] pollAddr = 5'h00, faultResetAddr = 5'h00, telegramAddr;
	logic [3:0] corrupt = 4'h0, telegramCode, diagWord;
	logic telegramValid;
	logic [1:0] enableCh1, enableCh2, twoChannel = 2'h1;
	logic [30:0] slaveFault, slaveEnable = 31'h3, tripMapCirc0 = 31'h1, tripMapCirc1 = 31'h2;
	int seed = 86959, err_total = 0, checks = 0;
	wire logic [8:0] obs = {diagWord[3], slaveFault[1:0], enableCh2, enableCh1, diagWord[2:1]};
	scm_slave_model i_scm_slave_model (
		.clk(clk),
		.poll(poll),
		.pollAddr(pollAddr),
		.corrupt(corrupt),
		.telegramValid(telegramValid),
		.telegramAddr(telegramAddr),
		.telegramCode(telegramCode)
	);
	scm_monitor #(
		.SHUTDOWN_CYCLES(SHUT),
		.RESTART_CYCLES(REST)
	) i_scm_monitor (
		.clk(clk),
		.reset(reset),
		.telegramValid(telegramValid),
		.telegramAddr(telegramAddr),
		.telegramCode(telegramCode),
		.learnRequest(learnRequest),
		.slaveEnable(slaveEnable),
		.tripMapCirc0(tripMapCirc0),
		.tripMapCirc1(tripMapCirc1),
		.twoChannel(twoChannel),
		.faultResetValid(faultResetValid),
		.faultResetAddr(faultResetAddr),
		.enableCh1(enableCh1),
		.enableCh2(enableCh2),
		.slaveFault(slaveFault),
		.diagWord(diagWord)
	);
	initial forever #2 clk = ~clk;
	// a circuit opens when any slave mapped to it trips
	function automatic logic [8:0] expect_run(input logic [30:0] f);
		logic [1:0] en;
		en = ~{|(f & tripMapCirc1), |(f & tripMapCirc0)};
		return {1'b0, f[1:0], en & twoChannel, en, en};
	endfunction
	task chk(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// at most one poll a cycle, slaves 1 and 2 alternate, random junk to unused slots
	task run(input int n, input logic [4:0] skip, input logic [3:0] bad, input logic [4:0] rst);
		logic [31:0] r;
		logic [4:0] a;
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			a = i[0] ? 5'h02 : 5'h01;
			if (r[1:0] == 2'h0 && bad == 4'h0) a = (r[6:2] < 5'h03) ? 5'h00 : r[6:2];
			poll = (a != skip);
			pollAddr = a;
			corrupt = (a > 5'h02 || a == 5'h00) ? r[10:7] : (a == 5'h02 ? bad : 4'h0);
			faultResetValid = (i == 0) && (rst != 5'h00);
			faultResetAddr = rst;
			@(negedge clk);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#(4 * 5000);
		err_total++;
		finish_test;
	end
	initial begin
		repeat (20) @(negedge clk);
		reset = 1'b0;
		run(4, 0, 0, 0);
		chk(obs & 9'h13f, 9'h100);
		run(60 + REST + 10, 0, 0, 0);
		chk(obs, expect_run(31'h0));
		run(2, 0, 4'h5, 0);
		run(2, 0, 0, 0);
		chk(obs, expect_run(31'h2));
		run(REST + 20, 0, 0, 0);
		chk(obs, expect_run(31'h2));
		run(4, 0, 0, 5'h01);
		chk(obs, expect_run(31'h2));
		run(3, 0, 0, 5'h02);
		chk(obs, expect_run(31'h2) & 9'h03f);
		run(REST - 10, 0, 0, 0);
		chk(obs, expect_run(31'h2) & 9'h03f);
		run(20, 0, 0, 0);
		chk(obs, expect_run(31'h0));
		run(SHUT + 10, 5'h01, 0, 0);
		chk(obs, expect_run(31'h1));
		run(10, 0, 0, 0);
		run(REST + 20, 0, 0, 5'h01);
		chk(obs, expect_run(31'h0));
		learnRequest = 1'b1;
		run(4, 0, 0, 0);
		chk(obs & 9'h13f, 9'h100);
		learnRequest = 1'b0;
		run(4, 0, 0, 0);
		chk(obs & 9'h13f, 9'h100);
		run(60 + REST + 10, 0, 0, 0);
		chk(obs, expect_run(31'h0));
		finish_test;
	end
endmodule // tb

// file: verilog/scm_monitor.sv
// safe code sequence monitor top: slave checks, shutdown logic, enabling circuits
`timescale 1ns/10ps
module scm_monitor #(
	parameter int SLAVES = scm_pkg::SLAVE_COUNT,
	parameter int CIRCUITS = scm_pkg::CIRCUIT_COUNT,
	parameter int SHUTDOWN_CYCLES = scm_pkg::SHUTDOWN_CYCLES,
	parameter int RESTART_CYCLES = scm_pkg::RESTART_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// received telegram, one per polled safe slave
	input wire logic telegramValid,
	input wire logic [scm_pkg::ADDR_WIDTH-1:0] telegramAddr,
	input wire logic [scm_pkg::CODE_WIDTH-1:0] telegramCode,
	// configuration
	input wire logic learnRequest,
	input wire logic [SLAVES-1:0] slaveEnable,
	input wire logic [SLAVES-1:0] tripMapCirc0,
	input wire logic [SLAVES-1:0] tripMapCirc1,
	input wire logic [CIRCUITS-1:0] twoChannel,
	// fault reset from a standard slave
	input wire logic faultResetValid,
	input wire logic [scm_pkg::ADDR_WIDTH-1:0] faultResetAddr,
	// enabling circuit outputs, channel one and two
	output logic [CIRCUITS-1:0] enableCh1,
	output logic [CIRCUITS-1:0] enableCh2,
	// diagnostics
	output logic [SLAVES-1:0] slaveFault,
	output logic [3:0] diagWord
);
	scm_pkg::scm_mode_type mode_reg;
	logic learnMode;
	logic [SLAVES-1:0] codeHit;
	logic [SLAVES-1:0] clearHit;
	logic [SLAVES-1:0] learnedAll;
	logic [SLAVES-1:0] faultAll;
	logic [CIRCUITS-1:0] cause;
	logic [CIRCUITS-1:0] closeNow;
	logic [CIRCUITS-1:0] closed_reg;
	logic [scm_pkg::TIMER_WIDTH-1:0] restartCnt_reg [CIRCUITS];
	logic [CIRCUITS-1:0] ch1_reg;
	logic [CIRCUITS-1:0] ch2_reg;
	logic [SLAVES-1:0] fault_reg;
	logic [3:0] diag_reg;

	// address decode shared by telegram and fault-reset paths
	function automatic logic hits(input logic [scm_pkg::ADDR_WIDTH-1:0] addr, input int slot);
		hits = (addr == scm_pkg::ADDR_WIDTH'(slot + 1));
	endfunction

	// a circuit trips when any slave routed to it holds a latched fault
	function automatic logic tripped(input logic [SLAVES-1:0] faults, input logic [SLAVES-1:0] map);
		tripped = |(faults & map);
	endfunction

	// one-hot slot selects; address 0 matches no slot and is dropped here
	always_comb begin
		codeHit = '0;
		clearHit = '0;
		for (int k = 0; k < SLAVES; k++) begin
			codeHit[k] = telegramValid && hits(telegramAddr, k);
			clearHit[k] = faultResetValid && hits(faultResetAddr, k);
		end
	end

	assign learnMode = (mode_reg == scm_pkg::SCM_LEARN);

	// bus slave addresses 1..31 map to slots 0..30
	genvar s;
	generate
		for (s = 0; s < SLAVES; s++) begin : g_slave
			scm_slave_check #(
				.TIMEOUT_CYCLES(SHUTDOWN_CYCLES)
			) u_check (
				.clk(clk),
				.reset(reset),
				.enabled(slaveEnable[s]),
				.learnMode(learnMode),
				.faultClear(clearHit[s]),
				.codeValid(codeHit[s]),
				.codeWord(telegramCode),
				.learned(learnedAll[s]),
				.fault(faultAll[s])
			);
		end
	endgenerate

	// leave learn mode once every enabled slave has a full reference
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_reg <= scm_pkg::SCM_LEARN;
		end else if (learnRequest) begin
			mode_reg <= scm_pkg::SCM_LEARN;
		end else begin
			unique case (mode_reg)
				scm_pkg::SCM_LEARN: begin
					if (((learnedAll & slaveEnable) == slaveEnable) && (slaveEnable != '0)) begin
						mode_reg <= scm_pkg::SCM_RUN;
					end
				end
				scm_pkg::SCM_RUN: begin
					mode_reg <= scm_pkg::SCM_RUN;
				end
			endcase
		end
	end

	// trip map routes each slave fault to its circuits; learn mode holds everything open
	always_comb begin
		cause = '0;
		cause[0] = tripped(faultAll, tripMapCirc0) || learnMode;
		if (CIRCUITS > 1) begin
			cause[CIRCUITS-1] = tripped(faultAll, tripMapCirc1) || learnMode;
		end
	end

	// one closing decision feeds both channels and the diagnostic image; channel two differs only where twoChannel masks it
	assign closeNow = closed_reg & ~cause;

	// restart delay counts only while the cause stays away
	genvar c;
	generate
		for (c = 0; c < CIRCUITS; c++) begin : g_circ
			always_ff @(posedge clk) begin
				if (reset || cause[c]) begin
					restartCnt_reg[c] <= '0;
				end else if (restartCnt_reg[c] < scm_pkg::TIMER_WIDTH'(RESTART_CYCLES)) begin
					restartCnt_reg[c] <= restartCnt_reg[c] + 32'h1;
				end
			end
			always_ff @(posedge clk) begin
				if (reset || cause[c]) begin
					closed_reg[c] <= 1'b0;
				end else if (restartCnt_reg[c] >= scm_pkg::TIMER_WIDTH'(RESTART_CYCLES)) begin
					closed_reg[c] <= 1'b1;
				end
			end
			always_ff @(posedge clk) begin
				if (reset) begin
					ch1_reg[c] <= 1'b0;
				end else begin
					ch1_reg[c] <= closeNow[c];
				end
			end
			// second channel mirrors the first only when configured two-channel
			always_ff @(posedge clk) begin
				if (reset) begin
					ch2_reg[c] <= 1'b0;
				end else begin
					ch2_reg[c] <= closeNow[c] && twoChannel[c];
				end
			end
		end
	endgenerate

	// diagnostic image for the master, informative only
	always_ff @(posedge clk) begin
		if (reset) begin
			fault_reg <= '0;
		end else begin
			fault_reg <= faultAll;
		end
	end

	// circuit bits follow the channel one enable outputs cycle for cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			diag_reg <= 4'h0;
		end else begin
			diag_reg[scm_pkg::DIAG_FAULT_BIT] <= |faultAll;
			diag_reg[scm_pkg::DIAG_CIRC0_BIT] <= closeNow[0];
			diag_reg[scm_pkg::DIAG_CIRC1_BIT] <= closeNow[CIRCUITS-1];
			diag_reg[scm_pkg::DIAG_LEARN_BIT] <= learnMode;
		end
	end

	assign enableCh1 = ch1_reg;
	assign enableCh2 = ch2_reg;
	assign slaveFault = fault_reg;
	assign diagWord = diag_reg;
endmodule : scm_monitor

// file: verilog/scm_pkg.sv
// constants shared by the safe code sequence monitor
package scm_pkg;
	localparam int SLAVE_COUNT = 31;
	localparam int ADDR_WIDTH = 5;
	localparam int CODE_WIDTH = 4;
	localparam int SEQ_LEN = 8;
	localparam int SEQ_IDX_WIDTH = 3;
	localparam int CIRCUIT_COUNT = 2;
	localparam int CLOCK_MHZ = 250;
	localparam int SHUTDOWN_MS = 40;
	localparam int RESTART_MS = 100;
	// longest time rounds down, least time rounds up; both exact at 250 MHz
	localparam int SHUTDOWN_CYCLES = SHUTDOWN_MS * 1000 * CLOCK_MHZ;
	localparam int RESTART_CYCLES = RESTART_MS * 1000 * CLOCK_MHZ;
	localparam int TIMER_WIDTH = 32;
	// diagnostic word layout
	localparam int DIAG_FAULT_BIT = 0;
	localparam int DIAG_CIRC0_BIT = 1;
	localparam int DIAG_CIRC1_BIT = 2;
	localparam int DIAG_LEARN_BIT = 3;
	typedef enum {
		SCM_LEARN,
		SCM_RUN
	} scm_mode_type;
endpackage : scm_pkg

// file: verilog/scm_slave_check.sv
// per-slave sequence store, learner, comparator and telegram watchdog
`timescale 1ns/10ps
module scm_slave_check #(
	parameter int TIMEOUT_CYCLES = scm_pkg::SHUTDOWN_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic enabled,
	input wire logic learnMode,
	input wire logic faultClear,
	// received telegram for this slave
	input wire logic codeValid,
	input wire logic [scm_pkg::CODE_WIDTH-1:0] codeWord,
	// result
	output logic learned,
	output logic fault
);
	logic [scm_pkg::CODE_WIDTH-1:0] seqMem [scm_pkg::SEQ_LEN];
	logic [scm_pkg::SEQ_IDX_WIDTH-1:0] idx_reg;
	localparam int CNT_WIDTH = scm_pkg::SEQ_IDX_WIDTH + 1;
	logic learned_reg;
	logic [CNT_WIDTH-1:0] learnCnt_reg;
	logic fault_reg;
	logic [scm_pkg::TIMER_WIDTH-1:0] silence_reg;
	logic mismatch;
	logic timeout;

	assign mismatch = codeValid && (seqMem[idx_reg] != codeWord);
	assign timeout = (silence_reg >= scm_pkg::TIMER_WIDTH'(TIMEOUT_CYCLES));
	assign learned = (learnCnt_reg == CNT_WIDTH'(scm_pkg::SEQ_LEN));
	assign fault = fault_reg;

	// reference store written on every telegram while in learn mode
	always_ff @(posedge clk) begin
		if (enabled && learnMode && codeValid) begin
			seqMem[idx_reg] <= codeWord;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !enabled) begin
			idx_reg <= '0;
		end else if (codeValid) begin
			idx_reg <= idx_reg + 3'h1;
		end
	end

	// fresh count on every entry to learn mode, so a relearn rewrites all eight words
	always_ff @(posedge clk) begin
		if (reset || !enabled || !learnMode) begin
			learnCnt_reg <= '0;
		end else if (codeValid && !learned) begin
			learnCnt_reg <= learnCnt_reg + CNT_WIDTH'(1);
		end
	end

	// run mode needs a complete reference from the latest learn pass
	always_ff @(posedge clk) begin
		if (reset || !enabled) begin
			learned_reg <= 1'b0;
		end else if (learnMode) begin
			learned_reg <= learned;
		end
	end

	// silence counter restarts on each telegram
	always_ff @(posedge clk) begin
		if (reset || !enabled || learnMode || codeValid) begin
			silence_reg <= '0;
		end else if (!timeout) begin
			silence_reg <= silence_reg + 32'h1;
		end
	end

	// fault latches; new fault wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			fault_reg <= 1'b0;
		end else if (enabled && !learnMode && (mismatch || timeout || !learned_reg)) begin
			fault_reg <= 1'b1;
		end else if (faultClear || !enabled || learnMode) begin
			fault_reg <= 1'b0;
		end
	end
endmodule : scm_slave_check
